// File: rtl/rim_mask_regs.sv
/*
  Interrupt mask registers of the regulator block: top miscellaneous
  mask, converter mask and linear regulator mask, with the event logic
  that they gate. Assumes a byte register port in the core domain
  (fed by the serial interface), an otp value for the reset-interrupt
  mask valid while rst_n is low, and flag clears from the flag registers.
*/
`timescale 1ns/1ps
module rim_mask_regs
#(
  parameter int RAILS = 2
)
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             otp_reset_mask,
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             reset_reg_event,
  input  wire logic             reset_reg_irq_clear,
  input  wire logic [RAILS-1:0] conv_pg_invalid,
  input  wire logic [RAILS-1:0] conv_curlim_active,
  input  wire logic [RAILS-1:0] conv_pg_irq_clear,
  input  wire logic [RAILS-1:0] conv_curlim_irq_clear,
  input  wire logic [RAILS-1:0] linreg_pg_invalid,
  input  wire logic [RAILS-1:0] linreg_curlim_active,
  input  wire logic [RAILS-1:0] linreg_pg_irq_clear,
  input  wire logic [RAILS-1:0] linreg_curlim_irq_clear,
  output logic                  reset_reg_irq_flag,
  output logic      [RAILS-1:0] conv_pg_raw,
  output logic      [RAILS-1:0] conv_curlim_raw,
  output logic      [RAILS-1:0] conv_pg_irq_flag,
  output logic      [RAILS-1:0] conv_curlim_irq_flag,
  output logic      [RAILS-1:0] linreg_pg_raw,
  output logic      [RAILS-1:0] linreg_curlim_raw,
  output logic      [RAILS-1:0] linreg_pg_irq_flag,
  output logic      [RAILS-1:0] linreg_curlim_irq_flag
);

  logic [7:0]       top_misc_irq_mask;
  logic [7:0]       converter_irq_mask;
  logic [7:0]       linreg_irq_mask;
  logic [RAILS-1:0] conv_fall_inh;
  logic [RAILS-1:0] conv_rise_inh;
  logic [RAILS-1:0] conv_cur_inh;
  logic [RAILS-1:0] lin_fall_inh;
  logic [RAILS-1:0] lin_rise_inh;
  logic [RAILS-1:0] lin_cur_inh;
  logic [7:0]       next_rdata;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // top miscellaneous mask
  // ----------------------------------------------------------------
  // bit 0 is reloaded from otp on every reset and ignores writes
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      top_misc_irq_mask <= {rim_pkg::RST_TOP_MISC[7:1], otp_reset_mask};
    else if (reg_wr && reg_addr == rim_pkg::ADDR_TOP_MISC_MASK)
      top_misc_irq_mask <= (reg_wdata & rim_pkg::WR_MASK_TOP_MISC)
                         | (top_misc_irq_mask & ~rim_pkg::WR_MASK_TOP_MISC);
  end

  property p_otp_load;
    $rose(rst_n) |-> top_misc_irq_mask[rim_pkg::BIT_RESET_REG_INHIBIT] == $past(otp_reset_mask);
  endproperty
  a_otp_load: assert property (@(posedge mclk) p_otp_load) else $error("otp mask not loaded");

  property p_otp_write_ignored;
    (reg_wr && reg_addr == rim_pkg::ADDR_TOP_MISC_MASK)
      |=> $stable(top_misc_irq_mask[rim_pkg::BIT_RESET_REG_INHIBIT]);
  endproperty
  a_otp_write_ignored: assert property (p_otp_write_ignored) else $error("reset mask bit written");

  // ----------------------------------------------------------------
  // rail mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      converter_irq_mask <= rim_pkg::RST_CONV_MASK;
    else if (reg_wr && reg_addr == rim_pkg::ADDR_CONV_MASK)
      converter_irq_mask <= reg_wdata & rim_pkg::WR_MASK_RAIL;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      linreg_irq_mask <= rim_pkg::RST_LINREG_MASK;
    else if (reg_wr && reg_addr == rim_pkg::ADDR_LINREG_MASK)
      linreg_irq_mask <= reg_wdata & rim_pkg::WR_MASK_RAIL;
  end

  property p_linreg_write;
    (reg_wr && reg_addr == rim_pkg::ADDR_LINREG_MASK)
      |=> linreg_irq_mask == ($past(reg_wdata) & rim_pkg::WR_MASK_RAIL);
  endproperty
  a_linreg_write: assert property (p_linreg_write) else $error("linreg mask write wrong");

  // ----------------------------------------------------------------
  // mask field decode
  // ----------------------------------------------------------------
  assign conv_fall_inh[1] = converter_irq_mask[rim_pkg::BIT_RAIL1_FALL];
  assign conv_rise_inh[1] = converter_irq_mask[rim_pkg::BIT_RAIL1_RISE];
  assign conv_cur_inh[1]  = converter_irq_mask[rim_pkg::BIT_RAIL1_CURLIM];
  assign conv_fall_inh[0] = converter_irq_mask[rim_pkg::BIT_RAIL0_FALL];
  assign conv_rise_inh[0] = converter_irq_mask[rim_pkg::BIT_RAIL0_RISE];
  assign conv_cur_inh[0]  = converter_irq_mask[rim_pkg::BIT_RAIL0_CURLIM];
  assign lin_fall_inh[1]  = linreg_irq_mask[rim_pkg::BIT_RAIL1_FALL];
  assign lin_rise_inh[1]  = linreg_irq_mask[rim_pkg::BIT_RAIL1_RISE];
  assign lin_cur_inh[1]   = linreg_irq_mask[rim_pkg::BIT_RAIL1_CURLIM];
  assign lin_fall_inh[0]  = linreg_irq_mask[rim_pkg::BIT_RAIL0_FALL];
  assign lin_rise_inh[0]  = linreg_irq_mask[rim_pkg::BIT_RAIL0_RISE];
  assign lin_cur_inh[0]   = linreg_irq_mask[rim_pkg::BIT_RAIL0_CURLIM];

  // ----------------------------------------------------------------
  // rail event detectors
  // ----------------------------------------------------------------
  for (genvar r = 0; r < RAILS; r++)
  begin : g_rail
    rim_rail_events u_conv
    (
      .mclk            (mclk),
      .rst_n           (rst_n),
      .pg_invalid      (conv_pg_invalid[r]),
      .curlim_active   (conv_curlim_active[r]),
      .pg_fall_inhibit (conv_fall_inh[r]),
      .pg_rise_inhibit (conv_rise_inh[r]),
      .curlim_inhibit  (conv_cur_inh[r]),
      .pg_clear        (conv_pg_irq_clear[r]),
      .curlim_clear    (conv_curlim_irq_clear[r]),
      .pg_raw          (conv_pg_raw[r]),
      .curlim_raw      (conv_curlim_raw[r]),
      .pg_irq_flag     (conv_pg_irq_flag[r]),
      .curlim_irq_flag (conv_curlim_irq_flag[r])
    );
    rim_rail_events u_lin
    (
      .mclk            (mclk),
      .rst_n           (rst_n),
      .pg_invalid      (linreg_pg_invalid[r]),
      .curlim_active   (linreg_curlim_active[r]),
      .pg_fall_inhibit (lin_fall_inh[r]),
      .pg_rise_inhibit (lin_rise_inh[r]),
      .curlim_inhibit  (lin_cur_inh[r]),
      .pg_clear        (linreg_pg_irq_clear[r]),
      .curlim_clear    (linreg_curlim_irq_clear[r]),
      .pg_raw          (linreg_pg_raw[r]),
      .curlim_raw      (linreg_curlim_raw[r]),
      .pg_irq_flag     (linreg_pg_irq_flag[r]),
      .curlim_irq_flag (linreg_curlim_irq_flag[r])
    );
  end

  property p_c1_fall_masked;
    ($rose(conv_pg_raw[1]) && $past(converter_irq_mask[rim_pkg::BIT_RAIL1_FALL]) && !$past(conv_pg_irq_flag[1]))
      |-> !conv_pg_irq_flag[1];
  endproperty
  a_c1_fall_masked: assert property (p_c1_fall_masked) else $error("conv1 invalid edge not masked");

  property p_c1_rise_open;
    ($fell(conv_pg_raw[1]) && !$past(converter_irq_mask[rim_pkg::BIT_RAIL1_RISE])) |-> conv_pg_irq_flag[1];
  endproperty
  a_c1_rise_open: assert property (p_c1_rise_open) else $error("conv1 valid edge not flagged");

  property p_c1_cur_masked;
    ($rose(conv_curlim_raw[1]) && $past(converter_irq_mask[rim_pkg::BIT_RAIL1_CURLIM])
      && !$past(conv_curlim_irq_flag[1])) |-> !conv_curlim_irq_flag[1];
  endproperty
  a_c1_cur_masked: assert property (p_c1_cur_masked) else $error("conv1 curlim not masked");

  property p_c0_fall_open;
    ($rose(conv_pg_raw[0]) && !$past(converter_irq_mask[rim_pkg::BIT_RAIL0_FALL])) |-> conv_pg_irq_flag[0];
  endproperty
  a_c0_fall_open: assert property (p_c0_fall_open) else $error("conv0 invalid edge not flagged");

  property p_c0_rise_masked;
    ($fell(conv_pg_raw[0]) && $past(converter_irq_mask[rim_pkg::BIT_RAIL0_RISE]) && !$past(conv_pg_irq_flag[0]))
      |-> !conv_pg_irq_flag[0];
  endproperty
  a_c0_rise_masked: assert property (p_c0_rise_masked) else $error("conv0 valid edge not masked");

  property p_c0_cur_cause;
    $rose(conv_curlim_irq_flag[0])
      |-> $rose(conv_curlim_raw[0]) && !$past(converter_irq_mask[rim_pkg::BIT_RAIL0_CURLIM]);
  endproperty
  a_c0_cur_cause: assert property (p_c0_cur_cause) else $error("conv0 curlim flag without cause");

  property p_raw_follows;
    $past(converter_irq_mask) == 8'hdd |-> conv_curlim_raw == $past(conv_curlim_active);
  endproperty
  a_raw_follows: assert property (p_raw_follows) else $error("raw curlim stalled by mask");

  property p_pg_polarity;
    ##1 conv_pg_raw == $past(conv_pg_invalid, 1);
  endproperty
  a_pg_polarity: assert property (p_pg_polarity) else $error("raw pg polarity wrong");

  // ----------------------------------------------------------------
  // register-reset interrupt flag
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      reset_reg_irq_flag <= 1'b0;
    else if (reset_reg_event && !top_misc_irq_mask[rim_pkg::BIT_RESET_REG_INHIBIT])
      reset_reg_irq_flag <= 1'b1;
    else if (reset_reg_irq_clear)
      reset_reg_irq_flag <= 1'b0;
  end

  property p_reset_gate;
    (reset_reg_event && top_misc_irq_mask[rim_pkg::BIT_RESET_REG_INHIBIT] && !reset_reg_irq_flag)
      |=> !reset_reg_irq_flag;
  endproperty
  a_reset_gate: assert property (p_reset_gate) else $error("reset interrupt not masked");

  property p_reset_open;
    (reset_reg_event && !top_misc_irq_mask[rim_pkg::BIT_RESET_REG_INHIBIT]) |=> reset_reg_irq_flag;
  endproperty
  a_reset_open: assert property (p_reset_open) else $error("reset interrupt not raised");

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb
  begin
    case (reg_addr)
      rim_pkg::ADDR_TOP_MISC_MASK: next_rdata = top_misc_irq_mask;
      rim_pkg::ADDR_CONV_MASK:     next_rdata = converter_irq_mask;
      rim_pkg::ADDR_LINREG_MASK:   next_rdata = linreg_irq_mask;
      default:                     next_rdata = rim_pkg::RDATA_UNMAPPED;
    endcase
  end

  // data holds between reads so a slow serial shifter can take it
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      reg_rdata <= rim_pkg::RDATA_UNMAPPED;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // scenario coverage
  // ----------------------------------------------------------------
  c_masked_then_cleared: cover property (
    $rose(conv_pg_raw[0]) && $past(converter_irq_mask[rim_pkg::BIT_RAIL0_FALL]) ##[1:20]
    !converter_irq_mask[rim_pkg::BIT_RAIL0_FALL]);
  c_reset_flag: cover property ($rose(reset_reg_irq_flag));
  c_linreg_flag: cover property ($rose(linreg_curlim_irq_flag[1]));

endmodule // rim_mask_regs

// File: rtl/rim_pkg.sv
/*
  Constants of the regulator interrupt mask block: register addresses,
  mask field positions, writable-bit masks and reset values.
  Assumes an 8-bit register port in the core clock domain behind the
  serial control interface.
*/
package rim_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TOP_MISC_MASK = 8'h21;
  localparam logic [7:0] ADDR_CONV_MASK     = 8'h22;
  localparam logic [7:0] ADDR_LINREG_MASK   = 8'h23;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_RESET_REG_INHIBIT = 0;
  localparam int BIT_RAIL1_FALL        = 7;
  localparam int BIT_RAIL1_RISE        = 6;
  localparam int BIT_RAIL1_CURLIM      = 4;
  localparam int BIT_RAIL0_FALL        = 3;
  localparam int BIT_RAIL0_RISE        = 2;
  localparam int BIT_RAIL0_CURLIM      = 0;

  // ----------------------------------------------------------------
  // writable bits and reset values
  // ----------------------------------------------------------------
  // bit 0 of the top register is loaded from otp, never from the bus
  localparam logic [7:0] WR_MASK_TOP_MISC   = 8'hfe;
  // bits 5 and 1 are reserved read-only zero
  localparam logic [7:0] WR_MASK_RAIL       = 8'hdd;
  localparam logic [7:0] RST_TOP_MISC       = 8'h00;
  localparam logic [7:0] RST_CONV_MASK      = 8'h00;
  localparam logic [7:0] RST_LINREG_MASK    = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED     = 8'h00;

endpackage : rim_pkg

// File: rtl/rim_rail_events.sv
/*
  Event detector for one regulator rail: keeps the raw power-good and
  current-limit status and raises sticky interrupt flags on unmasked
  edges. Assumes status inputs already synchronous to mclk.
*/
`timescale 1ns/1ps
module rim_rail_events
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pg_invalid,
  input  wire logic curlim_active,
  input  wire logic pg_fall_inhibit,
  input  wire logic pg_rise_inhibit,
  input  wire logic curlim_inhibit,
  input  wire logic pg_clear,
  input  wire logic curlim_clear,
  output logic      pg_raw,
  output logic      curlim_raw,
  output logic      pg_irq_flag,
  output logic      curlim_irq_flag
);

  logic went_invalid;
  logic went_valid;
  logic curlim_rose;
  logic pg_event;
  logic curlim_event;

  // ----------------------------------------------------------------
  // edge detection against the stored raw status
  // ----------------------------------------------------------------
  assign went_invalid = pg_invalid & ~pg_raw;
  assign went_valid   = ~pg_invalid & pg_raw;
  assign curlim_rose  = curlim_active & ~curlim_raw;
  // mask sampled at detection, so a masked edge leaves nothing pending
  assign pg_event     = (went_invalid & ~pg_fall_inhibit) | (went_valid & ~pg_rise_inhibit);
  assign curlim_event = curlim_rose & ~curlim_inhibit;

  // ----------------------------------------------------------------
  // raw status, independent of any mask
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pg_raw     <= 1'b0;
      curlim_raw <= 1'b0;
    end
    else
    begin
      pg_raw     <= pg_invalid;
      curlim_raw <= curlim_active;
    end
  end

  // ----------------------------------------------------------------
  // sticky flags; a new event beats a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pg_irq_flag <= 1'b0;
    else if (pg_event)
      pg_irq_flag <= 1'b1;
    else if (pg_clear)
      pg_irq_flag <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      curlim_irq_flag <= 1'b0;
    else if (curlim_event)
      curlim_irq_flag <= 1'b1;
    else if (curlim_clear)
      curlim_irq_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_set_beats_clear;
    @(posedge mclk) disable iff (!rst_n)
    (pg_event && pg_clear) |=> pg_irq_flag;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("pg flag lost to clear");

  property p_masked_rise_silent;
    @(posedge mclk) disable iff (!rst_n)
    (went_valid && pg_rise_inhibit && !pg_irq_flag) |=> !pg_irq_flag;
  endproperty
  a_masked_rise_silent: assert property (p_masked_rise_silent) else $error("masked valid edge flagged");

endmodule // rim_rail_events

// File: tb/rim_host_model.sv
/*
  Host model of the register port: single byte writes and reads.
  Assumes the bench calls its tasks and that mclk runs free.
*/
`timescale 1ns/1ps
module rim_host_model
(
  input  wire logic       mclk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr  = 8'h5a;
    reg_wdata = 8'ha5;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // idle lines show the inverse so a stale value is never mistaken for data
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge mclk);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge mclk);
    data     = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~addr;
  endtask
endmodule // rim_host_model

// File: tb/rim_mask_regs_bench.sv
/*
  Self-checking bench of the interrupt mask registers.
  Assumes the host model drives the register port; events, clears and
  reset are driven here at the falling edge of mclk.
*/
`timescale 1ns/1ps
module rim_mask_regs_bench;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       otp_reset_mask = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd, reset_reg_irq_flag;
  logic       reset_reg_event = 1'b0;
  logic       reset_reg_irq_clear = 1'b0;
  logic [1:0] conv_pg_invalid = '0, conv_curlim_active = '0, conv_pg_irq_clear = '0, conv_curlim_irq_clear = '0;
  logic [1:0] linreg_pg_invalid = '0, linreg_curlim_active = '0, linreg_pg_irq_clear = '0;
  logic [1:0] linreg_curlim_irq_clear = '0;
  logic [1:0] conv_pg_raw, conv_curlim_raw, conv_pg_irq_flag, conv_curlim_irq_flag;
  logic [1:0] linreg_pg_raw, linreg_curlim_raw, linreg_pg_irq_flag, linreg_curlim_irq_flag;
  int         num_errors = 0;
  int         n_compared = 0;

  always #20 mclk = ~mclk;

  rim_host_model rim_host_model_inst (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);

  rim_mask_regs #(.RAILS(2)) rim_mask_regs_inst
  (
    .mclk, .rst_n, .otp_reset_mask, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reset_reg_event, .reset_reg_irq_clear, .conv_pg_invalid, .conv_curlim_active,
    .conv_pg_irq_clear, .conv_curlim_irq_clear, .linreg_pg_invalid, .linreg_curlim_active,
    .linreg_pg_irq_clear, .linreg_curlim_irq_clear, .reset_reg_irq_flag, .conv_pg_raw,
    .conv_curlim_raw, .conv_pg_irq_flag, .conv_curlim_irq_flag, .linreg_pg_raw,
    .linreg_curlim_raw, .linreg_pg_irq_flag, .linreg_curlim_irq_flag
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic clear_all();
    @(negedge mclk);
    {conv_pg_irq_clear, conv_curlim_irq_clear, linreg_pg_irq_clear, linreg_curlim_irq_clear} = 8'hff;
    reset_reg_irq_clear = 1'b1;
    @(negedge mclk);
    {conv_pg_irq_clear, conv_curlim_irq_clear, linreg_pg_irq_clear, linreg_curlim_irq_clear} = 8'h00;
    reset_reg_irq_clear = 1'b0;
  endtask

  // kind 0 invalid detection, 1 valid detection, 2 current limit
  task automatic set_in(input bit lin, input int r, input int k, input logic v);
    if (k == 2)
      if (lin) linreg_curlim_active[r] = v; else conv_curlim_active[r] = v;
    else
      if (lin) linreg_pg_invalid[r] = v; else conv_pg_invalid[r] = v;
  endtask

  function automatic logic [1:0] st(input bit lin, input int r, input int k);
    if (k == 2)
      return lin ? {linreg_curlim_raw[r], linreg_curlim_irq_flag[r]} : {conv_curlim_raw[r], conv_curlim_irq_flag[r]};
    return lin ? {linreg_pg_raw[r], linreg_pg_irq_flag[r]} : {conv_pg_raw[r], conv_pg_irq_flag[r]};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic regs_test();
    logic [7:0] d;
    rim_host_model_inst.rd(rim_pkg::ADDR_CONV_MASK, d);
    chk(d, rim_pkg::RST_CONV_MASK, "converter mask reset");
    rim_host_model_inst.wr(rim_pkg::ADDR_CONV_MASK, 8'hff);
    rim_host_model_inst.rd(rim_pkg::ADDR_CONV_MASK, d);
    chk(d, 8'hdd, "converter mask reserved bits");
    rim_host_model_inst.rd(rim_pkg::ADDR_LINREG_MASK, d);
    chk(d, rim_pkg::RST_LINREG_MASK, "linreg mask untouched");
    rim_host_model_inst.wr(rim_pkg::ADDR_LINREG_MASK, 8'h76);
    rim_host_model_inst.rd(rim_pkg::ADDR_LINREG_MASK, d);
    chk(d, 8'h54, "linreg mask readback");
    rim_host_model_inst.wr(8'h24, 8'hff);
    rim_host_model_inst.rd(8'h24, d);
    chk(d, rim_pkg::RDATA_UNMAPPED, "unmapped read");
  endtask

  task automatic top_test(input logic otp);
    logic [7:0] d;
    @(negedge mclk);
    rst_n          = 1'b0;
    otp_reset_mask = otp;
    cyc(3);
    rst_n = 1'b1;
    rim_host_model_inst.rd(rim_pkg::ADDR_TOP_MISC_MASK, d);
    chk(d, {7'h00, otp}, "top mask after reset");
    rim_host_model_inst.wr(rim_pkg::ADDR_TOP_MISC_MASK, {7'h52, ~otp});
    rim_host_model_inst.rd(rim_pkg::ADDR_TOP_MISC_MASK, d);
    chk(d, {7'h52, otp}, "top mask bit 0 write");
    reset_reg_event = 1'b1;
    @(negedge mclk);
    reset_reg_event = 1'b0;
    chk({7'h00, reset_reg_irq_flag}, {7'h00, ~otp}, "reset flag gating");
    clear_all();
    chk({7'h00, reset_reg_irq_flag}, 8'h00, "reset flag clear");
  endtask

  // event and clear in one cycle: the event must win; needs top bit 0 at zero
  task automatic race_test();
    rim_host_model_inst.wr(rim_pkg::ADDR_CONV_MASK, 8'h00);
    @(negedge mclk);
    conv_pg_invalid[0]   = 1'b1;
    conv_pg_irq_clear[0] = 1'b1;
    reset_reg_event      = 1'b1;
    reset_reg_irq_clear  = 1'b1;
    @(negedge mclk);
    conv_pg_irq_clear[0] = 1'b0;
    reset_reg_event      = 1'b0;
    reset_reg_irq_clear  = 1'b0;
    chk({6'h00, conv_pg_raw[0], conv_pg_irq_flag[0]}, 8'h03, "pg set against clear");
    chk({7'h00, reset_reg_irq_flag}, 8'h01, "reset set against clear");
    rim_host_model_inst.wr(rim_pkg::ADDR_CONV_MASK, rim_pkg::WR_MASK_RAIL);
    conv_pg_invalid[0] = 1'b0;
    cyc(2);
    clear_all();
    chk({6'h00, conv_pg_raw[0], conv_pg_irq_flag[0]}, 8'h00, "pg flag after clear");
    chk({7'h00, reset_reg_irq_flag}, 8'h00, "reset flag after clear");
  endtask

  task automatic trial(input bit lin, input int r, input int k, input bit masked);
    logic [7:0] addr;
    int         pos;
    logic       lvl;
    addr = lin ? rim_pkg::ADDR_LINREG_MASK : rim_pkg::ADDR_CONV_MASK;
    pos  = r * 4 + (k == 0 ? 3 : (k == 1 ? 2 : 0));
    lvl  = (k == 1);
    // park the input at its start level with everything masked
    rim_host_model_inst.wr(addr, rim_pkg::WR_MASK_RAIL);
    set_in(lin, r, k, lvl);
    cyc(2);
    clear_all();
    rim_host_model_inst.wr(addr, masked ? (8'h01 << pos) : 8'h00);
    set_in(lin, r, k, ~lvl);
    cyc(2);
    chk({6'h00, st(lin, r, k)}, {6'h00, ~lvl, ~masked}, "raw and flag");
    if (masked)
    begin
      rim_host_model_inst.wr(addr, 8'h00);
      cyc(2);
      chk({6'h00, st(lin, r, k)}, {6'h00, ~lvl, 1'b0}, "masked event later");
    end
    rim_host_model_inst.wr(addr, rim_pkg::WR_MASK_RAIL);
    set_in(lin, r, k, 1'b0);
    cyc(2);
    clear_all();
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    cyc(3);
    rst_n = 1'b1;
    regs_test();
    top_test(1'b1);
    top_test(1'b0);
    race_test();
    for (int lin = 0; lin < 2; lin++)
      for (int r = 0; r < 2; r++)
        for (int k = 0; k < 3; k++)
          for (int m = 0; m < 2; m++)
            trial(lin[0], r, k, m[0]);
    stop_test();
  end

  initial
  begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    stop_test();
  end
endmodule // rim_mask_regs_bench
